// *** logic/stack_cache_map.svh ***
/*
  Register offsets, field positions, reset values and sizes for the stack
  top register cache. Assumes inclusion by the package and by design files.
*/
`ifndef STACK_CACHE_MAP_SVH
`define STACK_CACHE_MAP_SVH

// ==========================================================================
// register byte offsets on the wishbone slave
`define OFF_CEILING      8'h00
`define OFF_FLOOR        8'h04
`define OFF_CONFIG       8'h08
`define OFF_STATUS_WORD  8'h0C
`define OFF_INT_SP       8'h10
`define OFF_PROG_CNT     8'h14
`define OFF_OPERAND      8'h18
`define OFF_COMMAND      8'h1C
`define OFF_STATE        8'h20
`define OFF_PROBE_ADDR   8'h24
`define OFF_PROBE_DATA   8'h28
`define OFF_MEM_RDATA    8'h2C

// ==========================================================================
// field positions and reset values
`define PSW_ISP_BIT      0
`define ST_BUSY_BIT      0
`define ST_HIT_BIT       1
`define ST_ACC_OFF_BIT   2
`define ST_MREQ_BIT      3
`define ST_MWE_BIT       4
`define CONFIG_RESET     32'h0000_0000
`define PTR_RESET        28'h000_0000

// ==========================================================================
// sizes
`define ENTRY_COUNT      64
`define BIG_FRAME_BYTES  256

`endif

// *** logic/stack_cache_pkg.sv ***
/*
  Types for the stack top register cache.
  Assumes stack_cache_map.svh is reachable on the include path.
*/
package stack_cache_pkg;
  `include "stack_cache_map.svh"

  typedef enum logic [2:0] {
    CMD_NONE, CMD_CALL, CMD_ENTER, CMD_RELEASE, CMD_RETURN, CMD_FILL, CMD_RESTORE
  } cmd_e;

  typedef enum logic [1:0] {
    MEM_IDLE, MEM_SPILL, MEM_REFILL
  } mem_op_e;

  typedef logic [27:0] qptr_t;
endpackage

// *** logic/mem_port_if.sv ***
/*
  Internal carrier between the cache engine and its memory sequencer.
  Assumes one clock; the sequencer owns the memory side of the bus.
*/
`timescale 1ns/1ps
interface mem_port_if;
  import stack_cache_pkg::*;
  logic        start;   // begin a quad-word transfer
  mem_op_e     op;      // spill or refill
  logic [27:0] qaddr;   // quad-word address
  logic [31:0] wdata;   // word to write
  logic [1:0]  widx;    // word index in quad
  logic        wstep;   // word accepted or returned
  logic [31:0] rdata;   // returned word
  logic        done;    // quad finished

  modport engine (output start, output op, output qaddr, output wdata,
                  input widx, input wstep, input rdata, input done);
  modport seq    (input start, input op, input qaddr, input wdata,
                  output widx, output wstep, output rdata, output done);
endinterface

// *** logic/quad_sequencer.sv ***
/*
  Moves one quad-word between the cache and main memory, word by word in
  address order. Assumes memory answers each word with i_mem_ack.
*/
`timescale 1ns/1ps
module quad_sequencer
  import stack_cache_pkg::*;
(
  input  wire logic        i_clk,       // core clock
  input  wire logic        i_rst_n,     // async reset, low
  mem_port_if.seq          mp,          // engine side
  output logic             o_req,       // memory request level
  output logic             o_we,        // write direction
  output logic [31:0]      o_addr,      // byte address
  output logic [31:0]      o_wdata,     // write data
  input  wire logic        i_ack,       // memory word ack
  input  wire logic [31:0] i_rdata      // memory read data
);
  typedef struct packed {
    logic        busy;
    logic        we;
    logic [27:0] qaddr;
    logic [1:0]  idx;
  } seq_s;

  seq_s s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!s_r.busy && mp.start) begin
      s_nxt.busy  = 1'b1;
      s_nxt.we    = (mp.op == MEM_SPILL);
      s_nxt.qaddr = mp.qaddr;
      s_nxt.idx   = 2'h0;
    end else if (s_r.busy && i_ack) begin
      s_nxt.idx = s_r.idx + 2'h1;
      if (s_r.idx == 2'h3) begin
        s_nxt.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // words go in ascending address order within the quad
  assign o_req     = s_r.busy;
  assign o_we      = s_r.we;
  assign o_addr    = {s_r.qaddr, s_r.idx, 2'h0};
  assign o_wdata   = mp.wdata;
  assign mp.widx   = s_r.idx;
  assign mp.wstep  = s_r.busy && i_ack;
  assign mp.rdata  = i_rdata;
  assign mp.done   = s_r.busy && i_ack && (s_r.idx == 2'h3);
endmodule

// *** logic/stack_cache.sv ***
/*
  Stack top register cache: 64 word circular bank bounded by floor and
  ceiling quad-word pointers, with frame maintenance commands, spill and
  refill engine and a classic wishbone register slave.
  Assumes the core drives data lookups on the probe port, memory answers
  quad-word transfers word by word, and software avoids the stack range.
*/
`timescale 1ns/1ps
`include "stack_cache_map.svh"

// Behaviour
// - stack data lives in 64 word registers used as a ring
// - two 28-bit quad pointers: floor lowest cached, ceiling just past highest
// - hit when floor <= address < ceiling
// - byte granular access, looks like normal memory
// - call pushes return address onto stack top, then branches
// - enter subtracts frame size from floor; only floor moves if room
// - without room, entries nearest ceiling spill to memory
// - frame under 256 bytes spills only the shortfall
// - frame of 256 bytes or more spills all, keeps part near floor
// - release adds operand to floor
// - return adds operand to floor, then branches to stored address
// - fill forms address from offset; inside range means no traffic
// - outside range refills quads at ceiling until met or full
// - context restore loads pointers, status, counter, then fills
// - accumulator is word above current pointer, chosen by status
// - accumulator off-chip when floor equals ceiling or interrupt stack current
// - any generated address in range is routed to the cache
// - configuration word clears to zero on reset
module stack_cache
  import stack_cache_pkg::*;
#(
  parameter int ENTRIES = `ENTRY_COUNT
) (
  input  wire logic        I_CLK,        // core clock
  input  wire logic        I_RST_N,      // async reset, low
  input  wire logic        I_WB_CYC,     // wishbone cycle
  input  wire logic        I_WB_STB,     // wishbone strobe
  input  wire logic        I_WB_WE,      // wishbone write
  input  wire logic [7:0]  I_WB_ADR,     // byte address
  input  wire logic [3:0]  I_WB_SEL,     // byte lanes
  input  wire logic [31:0] I_WB_DAT,     // write data
  output logic      [31:0] O_WB_DAT,     // read data
  output logic             O_WB_ACK,     // acknowledge
  output logic             O_MEM_REQ,    // memory request
  output logic             O_MEM_WE,     // memory write
  output logic      [31:0] O_MEM_ADDR,   // memory byte address
  output logic      [31:0] O_MEM_WDATA,  // memory write data
  input  wire logic        I_MEM_ACK,    // memory word ack
  input  wire logic [31:0] I_MEM_RDATA,  // memory read data
  output logic             O_BRANCH,     // branch pulse
  output logic      [31:0] O_BRANCH_PC,  // branch target
  output logic             O_BUSY        // maintenance busy
);
  localparam int IW = $clog2(ENTRIES);

  typedef enum logic [1:0] { ST_IDLE, ST_SPILL, ST_REFILL, ST_BRANCH } state_e;

  typedef struct packed {
    logic [ENTRIES-1:0][31:0] bank;
    qptr_t       ceiling;
    qptr_t       floor;
    logic [31:0] config_w;
    logic [31:0] processor_status_word;
    logic [31:0] int_sp;
    logic [31:0] pc;
    logic [31:0] operand;
    logic [31:0] probe_addr;
    logic [31:0] probe_data;
    logic [31:0] mem_last;
    logic [31:0] target;
    qptr_t       goal;
    state_e      state;
    logic        pending;
    logic        ack;
    logic [31:0] rdat;
    logic        branch;
    logic        big;
    logic        busy;
  } top_s;

  top_s s_r, s_nxt;
  mem_port_if mp();

  // ==========================================================================
  // helpers
  function automatic logic in_range(input logic [31:0] a, input qptr_t lo, input qptr_t hi);
    in_range = (a[31:4] >= lo) && (a[31:4] < hi);
  endfunction

  function automatic logic [IW-1:0] slot(input logic [31:0] a);
    slot = a[IW+1:2];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = sel[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction

  localparam logic [27:0] RING_QUADS = 28'(ENTRIES / 4);

  logic        req;
  logic [31:0] cur_sp;
  logic [31:0] acc_addr;
  logic        acc_off;
  logic [27:0] used_q;
  logic [27:0] frame_q;
  logic [31:0] fill_addr;

  always_comb begin
    req      = I_WB_CYC && I_WB_STB && !s_r.ack;
    cur_sp   = s_r.processor_status_word[`PSW_ISP_BIT] ? s_r.int_sp : {s_r.floor, 4'h0};
    acc_addr = cur_sp + 32'h4;
    acc_off  = (s_r.floor == s_r.ceiling) || s_r.processor_status_word[`PSW_ISP_BIT];
    used_q   = s_r.ceiling - s_r.floor;
    frame_q  = 28'((s_r.operand + 32'hF) >> 4);
    fill_addr = {s_r.floor, 4'h0} + s_r.operand;
  end

  // ==========================================================================
  // engine and register slave
  always_comb begin
    logic [27:0] nfloor;
    nfloor = '0;
    s_nxt = s_r;
    s_nxt.ack    = 1'b0;
    s_nxt.branch = 1'b0;

    case (s_r.state)
      ST_IDLE: begin
        s_nxt.pending = 1'b0;
        s_nxt.big     = 1'b0;
      end
      ST_SPILL: begin
        // quads nearest the ceiling go out first
        if (mp.wstep && mp.widx == 2'h3) begin
          s_nxt.ceiling = s_r.ceiling - 28'h1;
          if (s_r.ceiling - 28'h1 - s_nxt.floor <= s_r.goal) begin
            s_nxt.state = s_r.pending ? ST_BRANCH : ST_IDLE;
            if (s_r.big) begin
              // frame quads past the ring hold nothing yet, so they are dropped
              s_nxt.ceiling = s_r.floor + RING_QUADS;
            end
          end
        end
      end
      ST_REFILL: begin
        if (mp.wstep) begin
          s_nxt.bank[slot({s_r.ceiling, mp.widx, 2'h0})] = mp.rdata;
        end
        if (mp.done) begin
          s_nxt.ceiling = s_r.ceiling + 28'h1;
          if (s_r.ceiling + 28'h1 > s_r.goal || s_r.ceiling + 28'h1 - s_r.floor >= RING_QUADS)
          begin
            s_nxt.state = s_r.pending ? ST_BRANCH : ST_IDLE;
          end
        end
      end
      ST_BRANCH: begin
        s_nxt.branch = 1'b1;
        s_nxt.state  = ST_IDLE;
      end
      default: s_nxt.state = ST_IDLE;
    endcase

    if (req && s_r.state == ST_IDLE) begin
      s_nxt.ack  = 1'b1;
      s_nxt.rdat = 32'h0;
      if (I_WB_WE) begin
        case (I_WB_ADR)
          `OFF_CEILING:     s_nxt.ceiling    = I_WB_DAT[31:4];
          `OFF_FLOOR:       s_nxt.floor      = I_WB_DAT[31:4];
          `OFF_CONFIG:      s_nxt.config_w   = merge(s_r.config_w, I_WB_DAT, I_WB_SEL);
          `OFF_STATUS_WORD: s_nxt.processor_status_word        = merge(s_r.processor_status_word, I_WB_DAT, I_WB_SEL);
          `OFF_INT_SP:      s_nxt.int_sp     = merge(s_r.int_sp, I_WB_DAT, I_WB_SEL);
          `OFF_PROG_CNT:    s_nxt.pc         = merge(s_r.pc, I_WB_DAT, I_WB_SEL);
          `OFF_OPERAND:     s_nxt.operand    = merge(s_r.operand, I_WB_DAT, I_WB_SEL);
          `OFF_PROBE_ADDR:  s_nxt.probe_addr = I_WB_DAT;
          `OFF_PROBE_DATA: begin
            // byte lanes give byte granular stores into the bank
            if (in_range(s_r.probe_addr, s_r.floor, s_r.ceiling)) begin
              s_nxt.bank[slot(s_r.probe_addr)] =
                merge(s_r.bank[slot(s_r.probe_addr)], I_WB_DAT, I_WB_SEL);
            end
          end
          `OFF_COMMAND: begin
            case (cmd_e'(I_WB_DAT[2:0]))
              CMD_CALL: begin
                // push return address, then branch to target in operand
                nfloor = s_r.floor - 28'h1;
                s_nxt.floor = nfloor;
                s_nxt.bank[slot({nfloor, 4'hC})] = s_r.pc;
                s_nxt.target = s_r.operand;
                s_nxt.state  = ST_BRANCH;
                if (used_q + 28'h1 > RING_QUADS) begin
                  s_nxt.goal  = RING_QUADS - 28'h1;
                  s_nxt.state = ST_SPILL;
                  s_nxt.pending = 1'b1;
                end
              end
              CMD_ENTER: begin
                nfloor = s_r.floor - frame_q;
                s_nxt.floor = nfloor;
                if (s_r.operand >= 32'(`BIG_FRAME_BYTES)) begin
                  // every valid quad goes out; spill stops at the old floor
                  s_nxt.goal  = frame_q;
                  s_nxt.big   = 1'b1;
                  s_nxt.state = ST_SPILL;
                  if (used_q == 28'h0) begin
                    s_nxt.ceiling = nfloor + RING_QUADS;
                    s_nxt.state   = ST_IDLE;
                  end
                end else if (used_q + frame_q > RING_QUADS) begin
                  s_nxt.goal  = RING_QUADS;
                  s_nxt.state = ST_SPILL;
                end
              end
              CMD_RELEASE: s_nxt.floor = s_r.floor + frame_q;
              CMD_RETURN: begin
                s_nxt.floor  = s_r.floor + frame_q;
                s_nxt.target = s_r.bank[slot({s_r.floor + frame_q - 28'h1, 4'hC})];
                s_nxt.state  = ST_BRANCH;
              end
              CMD_FILL: begin
                if (!in_range(fill_addr, s_r.floor, s_r.ceiling)) begin
                  s_nxt.goal  = fill_addr[31:4];
                  s_nxt.state = ST_REFILL;
                end
              end
              CMD_RESTORE: begin
                // pointers, status and counter were staged; jump to pc after fill
                s_nxt.target  = s_r.pc;
                s_nxt.pending = 1'b1;
                s_nxt.state   = ST_BRANCH;
                if (!in_range(fill_addr, s_r.floor, s_r.ceiling)) begin
                  s_nxt.goal  = fill_addr[31:4];
                  s_nxt.state = ST_REFILL;
                end
              end
              default: ;
            endcase
          end
          default: ;
        endcase
      end else begin
        case (I_WB_ADR)
          `OFF_CEILING:     s_nxt.rdat = {s_r.ceiling, 4'h0};
          `OFF_FLOOR:       s_nxt.rdat = {s_r.floor, 4'h0};
          `OFF_CONFIG:      s_nxt.rdat = s_r.config_w;
          `OFF_STATUS_WORD: s_nxt.rdat = s_r.processor_status_word;
          `OFF_INT_SP:      s_nxt.rdat = s_r.int_sp;
          `OFF_PROG_CNT:    s_nxt.rdat = s_r.pc;
          `OFF_OPERAND:     s_nxt.rdat = s_r.operand;
          `OFF_STATE:       s_nxt.rdat = {27'h0, O_MEM_WE, O_MEM_REQ, acc_off,
                                          in_range(s_r.probe_addr, s_r.floor, s_r.ceiling),
                                          1'b0};
          `OFF_PROBE_ADDR:  s_nxt.rdat = s_r.probe_addr;
          `OFF_PROBE_DATA:  s_nxt.rdat = s_r.bank[slot(s_r.probe_addr)];
          `OFF_MEM_RDATA:   s_nxt.rdat = acc_addr;
          default:          s_nxt.rdat = 32'h0;
        endcase
      end
    end else if (req) begin
      // maintenance in flight: answer reads with status only
      s_nxt.ack  = 1'b1;
      s_nxt.rdat = (I_WB_ADR == `OFF_STATE) ? 32'h1 : 32'h0;
    end
    s_nxt.busy = (s_nxt.state != ST_IDLE);
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // memory sequencer hookup
  assign mp.start = (s_r.state == ST_SPILL || s_r.state == ST_REFILL) && !O_MEM_REQ
                    && !mp.done;
  assign mp.op    = (s_r.state == ST_SPILL) ? MEM_SPILL : MEM_REFILL;
  assign mp.qaddr = (s_r.state == ST_SPILL) ? s_r.ceiling - 28'h1 : s_r.ceiling;
  assign mp.wdata = s_r.bank[slot({s_r.ceiling - 28'h1, mp.widx, 2'h0})];

  logic        mreq, mwe;
  logic [31:0] maddr, mwdata;

  quad_sequencer u_seq (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .mp      (mp),
    .o_req   (mreq),
    .o_we    (mwe),
    .o_addr  (maddr),
    .o_wdata (mwdata),
    .i_ack   (I_MEM_ACK),
    .i_rdata (I_MEM_RDATA)
  );

  assign O_MEM_REQ   = mreq;
  assign O_MEM_WE    = mwe;
  assign O_MEM_ADDR  = maddr;
  assign O_MEM_WDATA = mwdata;
  assign O_WB_DAT    = s_r.rdat;
  assign O_WB_ACK    = s_r.ack;
  assign O_BRANCH    = s_r.branch;
  assign O_BRANCH_PC = s_r.target;
  assign O_BUSY      = s_r.busy;

  // ==========================================================================
  // checks
  property p_reset_config;
    @(posedge I_CLK) $rose(I_RST_N) |-> s_r.config_w == 32'h0;
  endproperty
  a_reset_config: assert property (p_reset_config) else $error("config not zero");

  property p_release;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (req && I_WB_WE && I_WB_ADR == `OFF_COMMAND && I_WB_DAT[2:0] == 3'(CMD_RELEASE)
       && s_r.state == ST_IDLE) |=> s_r.floor == $past(s_r.floor) + $past(frame_q);
  endproperty
  a_release: assert property (p_release) else $error("release floor wrong");

  property p_branch_once;
    @(posedge I_CLK) disable iff (!I_RST_N) O_BRANCH |=> !O_BRANCH;
  endproperty
  a_branch_once: assert property (p_branch_once) else $error("branch held");

  property p_refill_up;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (s_r.state == ST_REFILL && mp.done) |=> s_r.ceiling == $past(s_r.ceiling) + 28'h1;
  endproperty
  a_refill_up: assert property (p_refill_up) else $error("ceiling not advanced");

  property p_spill_down;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (s_r.state == ST_SPILL && mp.done) |=>
        s_r.ceiling == (($past(s_r.big) && s_r.state == ST_IDLE) ? s_r.floor + RING_QUADS
                                                                 : $past(s_r.ceiling) - 28'h1);
  endproperty
  a_spill_down: assert property (p_spill_down) else $error("ceiling not lowered");

  property p_ack_pulse;
    @(posedge I_CLK) disable iff (!I_RST_N) O_WB_ACK |=> !O_WB_ACK;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");

  property p_acc_off;
    @(posedge I_CLK) disable iff (!I_RST_N)
      s_r.processor_status_word[`PSW_ISP_BIT] |-> acc_off;
  endproperty
  a_acc_off: assert property (p_acc_off) else $error("accumulator location");

  property p_mem_order;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (O_MEM_REQ && I_MEM_ACK && O_MEM_ADDR[3:2] != 2'h3) |=>
        O_MEM_ADDR == $past(O_MEM_ADDR) + 32'h4;
  endproperty
  a_mem_order: assert property (p_mem_order) else $error("word order");
endmodule

// *** tb/main_memory_model.sv ***
/*
  Main memory partner for the stack cache: answers each word of a quad
  transfer with a one-cycle ack after a random 0..3 cycle wait.
  Assumes the seed is set by the testbench; one clock shared with it.
*/
`timescale 1ns/1ps
module main_memory_model (
  input  wire logic        i_clk,    // core clock
  input  wire logic        i_req,    // quad transfer running
  input  wire logic        i_we,     // spill write
  input  wire logic [31:0] i_addr,   // word byte address
  input  wire logic [31:0] i_wdata,  // spill data
  output logic             o_ack,    // word taken or returned
  output logic      [31:0] o_rdata   // refill data
);
  // ========================================================================
  // word responder
  int wait_n = 0;
  initial o_ack = 1'b0;
  always @(posedge i_clk) begin
    o_ack   <= 1'b0;
    o_rdata <= $urandom;  // noise when idle, never the last word
    if (i_req === 1'b1 && o_ack !== 1'b1) begin
      if (wait_n == 0) begin
        o_ack   <= 1'b1;
        o_rdata <= i_we ? $urandom : i_addr ^ 32'hA5A5_0000;
        wait_n  <= $urandom_range(3, 0);
      end else begin
        wait_n <= wait_n - 1;
      end
    end
  end
endmodule

// *** tb/testbench.sv ***
/*
  Self-checking bench for the stack cache: wishbone register traffic,
  frame commands, probe accesses, two refills and two spills with the memory model.
  Assumes the design register map header and package are compiled first.
*/
`timescale 1ns/1ps
`include "stack_cache_map.svh"
module testbench;
  import stack_cache_pkg::*;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] dat = 32'h0000_0000, rdat, maddr, mwdata, mrdata, bpc;
  logic        ack, mreq, mwe, mack, br, busy;
  int          bad_count = 0, num_checks = 0;
  logic [31:0] eq[$], bq[$], mq[$], dq[$], pc, tgt, v, me;
  string       nq[$];

  always #10 clk = ~clk;

  stack_cache i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .O_MEM_REQ(mreq), .O_MEM_WE(mwe), .O_MEM_ADDR(maddr),
    .O_MEM_WDATA(mwdata), .I_MEM_ACK(mack), .I_MEM_RDATA(mrdata), .O_BRANCH(br),
    .O_BRANCH_PC(bpc), .O_BUSY(busy));
  main_memory_model i_mem (.i_clk(clk), .i_req(mreq), .i_we(mwe), .i_addr(maddr),
    .i_wdata(mwdata), .o_ack(mack), .o_rdata(mrdata));

  // ========================================================================
  // checking and verdict
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ========================================================================
  // result watchers, sampled mid-cycle where outputs are settled
  always @(negedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && eq.size() > 0)
      check(nq.pop_front(), rdat, eq.pop_front());
    if (br === 1'b1)
      check("branch target", bpc, bq.size() ? bq.pop_front() : 32'hXXXX_XXXX);
    if (mreq === 1'b1 && mack === 1'b1) begin
      // queued word address carries the expected direction in bit 0
      me = mq.size() ? mq.pop_front() : 32'hXXXX_XXXX;
      check("memory word address", maddr, {me[31:1], 1'b0});
      check("memory direction", {31'h0, mwe}, {31'h0, me[0]});
      if (me[0] === 1'b1)
        check("spill data", mwdata, dq.size() ? dq.pop_front() : 32'hXXXX_XXXX);
    end
  end

  // ========================================================================
  // wishbone classic master
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    // ack is sampled at the same rising edge that releases the request
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic expect_quad(input logic [31:0] base, input logic w);
    for (int i = 0; i < 4; i++) mq.push_back(base + 32'(i * 4) + {31'h0, w});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    eq.push_back(exp);
    nq.push_back(name);
    wb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic cmd(input cmd_e c, input logic [31:0] op);
    wb(1'b1, `OFF_OPERAND, op);
    wb(1'b1, `OFF_COMMAND, {29'h0, c});
    repeat (2) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
  endtask

  // ========================================================================
  // scenarios
  initial begin
    void'($urandom(94));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(`OFF_CEILING, 32'h0000_0000, "ceiling reset");
    rd(`OFF_FLOOR, 32'h0000_0000, "floor reset");
    rd(`OFF_CONFIG, 32'h0000_0000, "config reset");
    wb(1'b1, 8'hFC, 32'hFFFF_FFFF);
    rd(`OFF_CONFIG, 32'h0000_0000, "config after unmapped write");
    // empty cache: a small frame needs no spill
    wb(1'b1, `OFF_FLOOR, 32'h0000_0100);
    wb(1'b1, `OFF_CEILING, 32'h0000_0100);
    cmd(CMD_ENTER, 32'h0000_0010);
    rd(`OFF_FLOOR, 32'h0000_00F0, "floor after enter");
    rd(`OFF_CEILING, 32'h0000_0100, "ceiling after enter");
    // byte lanes merge into one cached word
    wb(1'b1, `OFF_PROBE_ADDR, 32'h0000_00F4);
    wb(1'b1, `OFF_PROBE_DATA, 32'h0000_CAFE);
    wb(1'b1, `OFF_PROBE_DATA, 32'h1234_5677, 4'h1);
    rd(`OFF_PROBE_DATA, 32'h0000_CA77, "probe byte write");
    rd(`OFF_MEM_RDATA, 32'h0000_00F4, "accumulator on floor");
    rd(`OFF_STATE, 32'h0000_0002, "state on floor");
    // interrupt stack kept clear of the cached range
    wb(1'b1, `OFF_INT_SP, 32'h0000_0800);
    wb(1'b1, `OFF_STATUS_WORD, 32'h0000_0001);
    rd(`OFF_MEM_RDATA, 32'h0000_0804, "accumulator on interrupt stack");
    rd(`OFF_STATE, 32'h0000_0006, "state on interrupt stack");
    wb(1'b1, `OFF_STATUS_WORD, 32'h0000_0000);
    cmd(CMD_RELEASE, 32'h0000_0010);
    rd(`OFF_FLOOR, 32'h0000_0100, "floor after release");
    // call pushes the return address just below the floor
    pc  = $urandom & 32'h00FF_FFFC;
    tgt = $urandom & 32'h00FF_FFFC;
    wb(1'b1, `OFF_PROG_CNT, pc);
    bq.push_back(tgt);
    cmd(CMD_CALL, tgt);
    wb(1'b1, `OFF_PROBE_ADDR, 32'h0000_00FC);
    rd(`OFF_PROBE_DATA, pc, "pushed return address");
    bq.push_back(pc);
    cmd(CMD_RETURN, 32'h0000_0010);
    rd(`OFF_FLOOR, 32'h0000_0100, "floor after return");
    // empty range at 0x200: ensure fill of 12 bytes refills one quad
    wb(1'b1, `OFF_FLOOR, 32'h0000_0200);
    wb(1'b1, `OFF_CEILING, 32'h0000_0200);
    expect_quad(32'h0000_0200, 1'b0);
    cmd(CMD_FILL, 32'h0000_000C);
    rd(`OFF_CEILING, 32'h0000_0210, "ceiling after fill");
    wb(1'b1, `OFF_PROBE_ADDR, 32'h0000_0208);
    rd(`OFF_PROBE_DATA, 32'hA5A5_0208, "refilled word");
    // restore stages pointers and counter, refills one quad, then branches
    pc = $urandom & 32'h00FF_FFFC;
    wb(1'b1, `OFF_FLOOR, 32'h0000_0300);
    wb(1'b1, `OFF_CEILING, 32'h0000_0300);
    wb(1'b1, `OFF_PROG_CNT, pc);
    expect_quad(32'h0000_0300, 1'b0);
    bq.push_back(pc);
    cmd(CMD_RESTORE, 32'h0000_0004);
    rd(`OFF_CEILING, 32'h0000_0310, "ceiling after restore");
    // full ring: a one quad frame spills the quad below the ceiling
    wb(1'b1, `OFF_FLOOR, 32'h0000_0400);
    wb(1'b1, `OFF_CEILING, 32'h0000_0500);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      dq.push_back(v);
      wb(1'b1, `OFF_PROBE_ADDR, 32'h0000_04F0 + 32'(i * 4));
      wb(1'b1, `OFF_PROBE_DATA, v);
    end
    expect_quad(32'h0000_04F0, 1'b1);
    cmd(CMD_ENTER, 32'h0000_0010);
    rd(`OFF_FLOOR, 32'h0000_03F0, "floor after spill");
    rd(`OFF_CEILING, 32'h0000_04F0, "ceiling after spill");
    // big frame flushes the valid quad; ring slots 0..3 still hold the restored quad
    wb(1'b1, `OFF_FLOOR, 32'h0000_0600);
    wb(1'b1, `OFF_CEILING, 32'h0000_0610);
    expect_quad(32'h0000_0600, 1'b1);
    for (int i = 0; i < 4; i++) dq.push_back(32'hA5A5_0300 + 32'(i * 4));
    cmd(CMD_ENTER, 32'h0000_0110);
    rd(`OFF_FLOOR, 32'h0000_04F0, "floor after big frame");
    rd(`OFF_CEILING, 32'h0000_05F0, "ceiling after big frame");
    check("words left unfetched", mq.size(), 32'h0000_0000);
    check("spill words left", dq.size(), 32'h0000_0000);
    check("branches left", bq.size(), 32'h0000_0000);
    repeat (4) @(posedge clk);
    end_of_test();
  end

  // ========================================================================
  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #(20 * 20000);
    bad_count++;
    end_of_test();
  end
endmodule
